// ---- design/ucr_defines.vh ----
// Purpose: shared constants of the serial control block
// Assumes: included by bare name from every design file
// Notes: byte addresses on the register bus, field positions, reset values
`ifndef UCR_DEFINES_VH
`define UCR_DEFINES_VH
`define UCR_ADDR_CTRL_ONE 8'h00
`define UCR_ADDR_CTRL_TWO 8'h04
`define UCR_ADDR_FLAGS 8'h08
`define UCR_ADDR_DATA 8'h0c
`define UCR_ADDR_PERIOD 8'h10
`define UCR_IDX_CTRL_ONE 3'h0
`define UCR_IDX_CTRL_TWO 3'h1
`define UCR_IDX_FLAGS 3'h2
`define UCR_IDX_DATA 3'h3
`define UCR_IDX_PERIOD 3'h4
`define UCR_IDX_NONE 3'h7
`define UCR_C1_RX9 7
`define UCR_C1_TX9 6
`define UCR_C1_SLEEP 5
`define UCR_C1_NINE 4
`define UCR_C1_ROUSE 3
`define UCR_C1_PAR_ON 2
`define UCR_C1_PAR_ODD 1
`define UCR_C1_PAR_IRQ 0
`define UCR_C2_TXBUF_IRQ 7
`define UCR_C2_TXDONE_IRQ 6
`define UCR_C2_RXDATA_IRQ 5
`define UCR_C2_IDLE_IRQ 4
`define UCR_C2_TX_ON 3
`define UCR_C2_RX_ON 2
`define UCR_C2_MUTE 1
`define UCR_C2_BRK 0
`define UCR_RST_CTRL_ONE 8'h00
`define UCR_RST_CTRL_TWO 8'h00
`define UCR_RST_PERIOD 16'h0010
`define UCR_RESP_OKAY 2'h0
`define UCR_RESP_SLVERR 2'h2
`endif

// ---- design/ucr_tx_engine.v ----
// Purpose: transmit frame engine with bit timer, preamble and break words
// Assumes: one clock, synchronous active-low reset, clock enable freezes all
// Notes: frame options are latched at frame start so changes apply to the next word
`timescale 1ns/10ps
`include "ucr_defines.vh"
module ucr_tx_engine (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire tx_on,
	input wire sleep,
	input wire nine,
	input wire par_on,
	input wire par_odd,
	input wire brk,
	input wire hold_full,
	input wire [7:0] hold_data,
	input wire ninth,
	input wire [15:0] bit_period,
	output reg take_q,
	output reg done_q,
	output reg line_q,
	output reg busy_q
);
	localparam S_IDLE = 2'd0;
	localparam S_WAIT = 2'd1;
	localparam S_SEND = 2'd2;
	localparam K_NONE = 2'd0;
	localparam K_DAT = 2'd1;
	localparam K_PRE = 2'd2;
	localparam K_BRK = 2'd3;
	reg [1:0] state_q;
	reg [1:0] kind_q;
	reg [15:0] cnt_q;
	reg [10:0] shift_q;
	reg [3:0] left_q;
	reg tx_on_d1_q;
	reg brk_d1_q;
	reg pre_pend_q;
	reg brk_pend_q;
	reg [1:0] nk;
	reg [10:0] ns;
	reg [8:0] word9;
	reg par_bit;
	wire [15:0] per_m1;
	wire tick;
	wire can_start;
	// a zero period is treated as one clock per bit
	assign per_m1 = (bit_period == 16'h0000) ? 16'h0000 : bit_period - 16'h0001;
	assign tick = (cnt_q >= per_m1);
	assign can_start = tx_on & ~sleep & (nk != K_NONE); // R2
	// next frame choice: break beats preamble beats data
	always @* begin
		par_bit = (nine ? ^hold_data : ^hold_data[6:0]) ^ par_odd; // R8
		word9 = {ninth, hold_data}; // R1
		if (par_on & nine)
			word9[8] = par_bit; // R6
		else if (par_on)
			word9[7] = par_bit; // R6
		if (brk | brk_pend_q) begin
			nk = K_BRK; // R20 R21
			ns = 11'h000; // R24
		end else if (pre_pend_q) begin
			nk = K_PRE; // R14
			ns = 11'h7ff;
		end else if (hold_full) begin
			nk = K_DAT;
			ns = nine ? {1'b1, word9, 1'b0} : {2'b11, word9[7:0], 1'b0}; // R3
		end else begin
			nk = K_NONE;
			ns = 11'h7ff;
		end
	end
	// frame sequencer; bit timer only runs while a frame or the start delay is active
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= S_IDLE;
			kind_q <= K_NONE;
			cnt_q <= 16'h0000;
			shift_q <= 11'h7ff;
			left_q <= 4'h0;
			tx_on_d1_q <= 1'b0;
			brk_d1_q <= 1'b0;
			pre_pend_q <= 1'b0;
			brk_pend_q <= 1'b0;
			take_q <= 1'b0;
			done_q <= 1'b0;
			line_q <= 1'b1;
			busy_q <= 1'b0;
		end else if (ce) begin
			tx_on_d1_q <= tx_on;
			brk_d1_q <= brk;
			take_q <= 1'b0;
			done_q <= 1'b0;
			cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
			if (state_q == S_IDLE)
				cnt_q <= 16'h0000;
			case (state_q)
			S_IDLE: begin
				line_q <= 1'b1;
				if (tx_on & ~tx_on_d1_q)
					state_q <= S_WAIT; // R15
				else if (can_start) begin
					state_q <= S_SEND;
					kind_q <= nk;
					shift_q <= ns; // R7
					line_q <= ns[0];
					left_q <= nine ? 4'd10 : 4'd9;
					take_q <= (nk == K_DAT); // R23
					busy_q <= 1'b1;
					if (nk == K_PRE)
						pre_pend_q <= 1'b0;
					if (nk == K_BRK)
						brk_pend_q <= 1'b0;
				end
			end
			S_WAIT: begin
				if (tick)
					state_q <= S_IDLE; // R15
			end
			S_SEND: begin
				if (tick && left_q == 4'h0) begin
					done_q <= (kind_q == K_DAT); // preamble and break do not count as done
					busy_q <= 1'b0;
					state_q <= S_IDLE;
					line_q <= 1'b1;
					if (can_start) begin
						state_q <= S_SEND;
						busy_q <= 1'b1;
						kind_q <= nk;
						shift_q <= ns;
						line_q <= ns[0];
						left_q <= nine ? 4'd10 : 4'd9;
						take_q <= (nk == K_DAT); // R23
						if (nk == K_PRE)
							pre_pend_q <= 1'b0;
						if (nk == K_BRK)
							brk_pend_q <= 1'b0;
					end
				end else if (tick) begin
					shift_q <= {1'b1, shift_q[10:1]};
					line_q <= shift_q[1];
					left_q <= left_q - 4'h1;
				end
			end
			default: state_q <= S_IDLE;
			endcase
			// requests are set last so they win over a clear in the same cycle
			if (tx_on & ~tx_on_d1_q & busy_q)
				pre_pend_q <= 1'b1; // R14
			if (brk & ~brk_d1_q)
				brk_pend_q <= 1'b1; // R21
		end
	end
endmodule

// ---- design/ucr_serial_top.v ----
// Purpose: control registers, receiver, flags and pin control of the async serial port
// Assumes: AXI4-Lite slave on aclk, rx_pin synchronous to aclk, ce freezes all state
// Notes: 8-bit registers sit in the low byte lane, upper bits read as zero
// Notes on behaviour
// (R1) ninth bit: received goes to rx_ninth_bit, transmitted taken from tx_ninth_bit.
// (R2) sleep stops bit timers and outputs after the current byte.
// (R3) word length selects 8 or 9 data bits, one start, one stop.
// (R4) software keeps word length steady during any transfer.
// (R5) rouse method picks idle-line or address-mark wake from mute.
// (R6) parity replaces the top data bit and is checked on reception.
// (R7) parity enable applies from the next byte, both directions.
// (R8) parity sense even or odd, changed from the next byte.
// (R9) parity fault requests the interrupt when enabled.
// (R10) empty holding register requests the interrupt while enabled.
// (R11) transmission done requests the interrupt while enabled.
// (R12) overrun or full receive buffer request the interrupt while enabled.
// (R13) idle-line flag requests the interrupt while enabled.
// (R14) transmit enable pulsed low then high sends a preamble after current word.
// (R15) one bit time passes after transmit enable before sending starts.
// (R16) tx pin is released only with both enables clear or tx never enabled; the code also releases it in sleep once the shifter is idle.
// (R17) receive enable starts the start-bit search; clear disables receiver.
// (R18) mute set by software, cleared by hardware on the chosen wake sequence.
// (R19) software lets some data arrive before muting with idle wake.
// (R20) break characters go out while send break is set.
// (R21) send break set then cleared sends one break after the current word.
// (R22) reset clears control one bits six to zero.
// (R23) holding register empty flag sets when data moves to the shifter.
// (R24) a break word holds the line low for a whole frame.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "ucr_defines.vh"
module ucr_serial_top (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire rx_pin,
	output wire tx_pin,
	output reg tx_pin_oe_q,
	output reg serial_irq_q
);
	localparam R_IDLE = 2'd0;
	localparam R_START = 2'd1;
	localparam R_BITS = 2'd2;
	reg [7:0] ctrl_one_q;
	reg [7:0] ctrl_two_q;
	reg [15:0] period_q;
	reg [7:0] tx_hold_q;
	reg [7:0] rx_data_q;
	reg txbuf_empty_q;
	reg tx_done_q;
	reg rxbuf_full_q;
	reg idle_flag_q;
	reg overrun_q;
	reg frame_err_q;
	reg parity_fault_q;
	reg flags_rd_q;
	reg tx_ever_q;
	reg aw_held_q;
	reg w_held_q;
	reg [7:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [1:0] rstate_q;
	reg [15:0] rcnt_q;
	reg [3:0] rbits_q;
	reg [8:0] rshift_q;
	reg rnine_q;
	reg rpar_on_q;
	reg rpar_odd_q;
	reg [3:0] ibits_q;
	reg idle_armed_q;
	reg [31:0] rd_val;
	reg [2:0] widx;
	reg [2:0] ridx;
	wire tx_take;
	wire tx_done_evt;
	wire tx_busy;
	wire wr_go;
	wire rd_go;
	wire [15:0] per_m1;
	wire rtick;
	wire rhalf;
	wire [7:0] flags_val;
	wire [8:0] rword;
	wire rx_msb;
	wire rx_par_bad;
	wire [3:0] frame_len;
	// register index from a byte address; unmapped addresses give the none index
	function [2:0] ucr_index;
		input [7:0] addr;
		begin
			case (addr)
			`UCR_ADDR_CTRL_ONE: ucr_index = `UCR_IDX_CTRL_ONE;
			`UCR_ADDR_CTRL_TWO: ucr_index = `UCR_IDX_CTRL_TWO;
			`UCR_ADDR_FLAGS: ucr_index = `UCR_IDX_FLAGS;
			`UCR_ADDR_DATA: ucr_index = `UCR_IDX_DATA;
			`UCR_ADDR_PERIOD: ucr_index = `UCR_IDX_PERIOD;
			default: ucr_index = `UCR_IDX_NONE;
			endcase
		end
	endfunction
	// transmitter; the holding register is full whenever the empty flag is low
	ucr_tx_engine u_tx (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.tx_on(ctrl_two_q[`UCR_C2_TX_ON]),
		.sleep(ctrl_one_q[`UCR_C1_SLEEP]),
		.nine(ctrl_one_q[`UCR_C1_NINE]),
		.par_on(ctrl_one_q[`UCR_C1_PAR_ON]),
		.par_odd(ctrl_one_q[`UCR_C1_PAR_ODD]),
		.brk(ctrl_two_q[`UCR_C2_BRK]),
		.hold_full(~txbuf_empty_q),
		.hold_data(tx_hold_q),
		.ninth(ctrl_one_q[`UCR_C1_TX9]),
		.bit_period(period_q),
		.take_q(tx_take),
		.done_q(tx_done_evt),
		.line_q(tx_pin),
		.busy_q(tx_busy)
	);
	// bus handshake decode
	assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
	assign rd_go = s_axi_arvalid & s_axi_arready;
	assign flags_val = {txbuf_empty_q, tx_done_q, rxbuf_full_q, idle_flag_q, overrun_q, 1'b0, frame_err_q,
		parity_fault_q};
	// receiver timing and word decode
	assign per_m1 = (period_q == 16'h0000) ? 16'h0000 : period_q - 16'h0001;
	assign rtick = (rcnt_q >= per_m1);
	assign rhalf = (rcnt_q >= {1'b0, per_m1[15:1]});
	assign rword = rnine_q ? rshift_q : {1'b0, rshift_q[8:1]};
	assign rx_msb = rnine_q ? rword[8] : rword[7];
	assign rx_par_bad = rpar_on_q & ((^rword) != rpar_odd_q); // R6
	assign frame_len = ctrl_one_q[`UCR_C1_NINE] ? 4'd11 : 4'd10;
	// read mux
	always @* begin
		ridx = ucr_index(s_axi_araddr);
		widx = ucr_index(aw_addr_q);
		case (ridx)
		`UCR_IDX_CTRL_ONE: rd_val = {24'h000000, ctrl_one_q};
		`UCR_IDX_CTRL_TWO: rd_val = {24'h000000, ctrl_two_q};
		`UCR_IDX_FLAGS: rd_val = {24'h000000, flags_val};
		`UCR_IDX_DATA: rd_val = {24'h000000, rx_data_q};
		`UCR_IDX_PERIOD: rd_val = {16'h0000, period_q};
		default: rd_val = 32'h00000000;
		endcase
	end
	// axi4-lite slave: address and data are taken in either order, one write at a time
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UCR_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `UCR_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (widx == `UCR_IDX_NONE) ? `UCR_RESP_SLVERR : `UCR_RESP_OKAY;
			end
			if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= (ridx == `UCR_IDX_NONE) ? `UCR_RESP_SLVERR : `UCR_RESP_OKAY;
			end
			if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
	// receiver: start-bit check at half a bit, then samples at bit centres
	always @(posedge aclk) begin
		if (!aresetn) begin
			rstate_q <= R_IDLE;
			rcnt_q <= 16'h0000;
			rbits_q <= 4'h0;
			rshift_q <= 9'h000;
			rnine_q <= 1'b0;
			rpar_on_q <= 1'b0;
			rpar_odd_q <= 1'b0;
			ibits_q <= 4'h0;
		end else if (ce) begin
			rcnt_q <= rtick ? 16'h0000 : rcnt_q + 16'h0001;
			case (rstate_q)
			R_IDLE: begin
				if (!ctrl_two_q[`UCR_C2_RX_ON] || ctrl_one_q[`UCR_C1_SLEEP]) begin
					rcnt_q <= 16'h0000; // R17 R2
					ibits_q <= 4'h0;
				end else if (!rx_pin) begin
					rstate_q <= R_START; // R17
					rcnt_q <= 16'h0000;
					ibits_q <= 4'h0;
				end else if (rtick && ibits_q != frame_len)
					ibits_q <= ibits_q + 4'h1;
			end
			R_START: begin
				if (rhalf) begin
					rcnt_q <= 16'h0000;
					rbits_q <= 4'h0;
					rstate_q <= rx_pin ? R_IDLE : R_BITS;
					rnine_q <= ctrl_one_q[`UCR_C1_NINE]; // R3
					rpar_on_q <= ctrl_one_q[`UCR_C1_PAR_ON]; // R7
					rpar_odd_q <= ctrl_one_q[`UCR_C1_PAR_ODD]; // R8
				end
			end
			R_BITS: begin
				if (rtick) begin
					rbits_q <= rbits_q + 4'h1;
					if (rbits_q != (rnine_q ? 4'd9 : 4'd8))
						rshift_q <= {rx_pin, rshift_q[8:1]};
					else
						rstate_q <= R_IDLE;
				end
			end
			default: rstate_q <= R_IDLE;
			endcase
		end
	end
	// registers and flags; hardware sets are placed after software clears so sets win
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_one_q <= `UCR_RST_CTRL_ONE; // R22
			ctrl_two_q <= `UCR_RST_CTRL_TWO;
			period_q <= `UCR_RST_PERIOD;
			tx_hold_q <= 8'h00;
			rx_data_q <= 8'h00;
			txbuf_empty_q <= 1'b1;
			tx_done_q <= 1'b1;
			rxbuf_full_q <= 1'b0;
			idle_flag_q <= 1'b0;
			overrun_q <= 1'b0;
			frame_err_q <= 1'b0;
			parity_fault_q <= 1'b0;
			flags_rd_q <= 1'b0;
			idle_armed_q <= 1'b0;
			tx_ever_q <= 1'b0;
			tx_pin_oe_q <= 1'b0;
			serial_irq_q <= 1'b0;
		end else if (ce) begin
			// a flags read arms the clearing sequence, a data access completes it
			if (rd_go && ridx == `UCR_IDX_FLAGS)
				flags_rd_q <= 1'b1;
			if (rd_go && ridx == `UCR_IDX_DATA && flags_rd_q) begin
				flags_rd_q <= 1'b0;
				rxbuf_full_q <= 1'b0;
				idle_flag_q <= 1'b0;
				overrun_q <= 1'b0;
				frame_err_q <= 1'b0;
				parity_fault_q <= 1'b0;
			end
			if (wr_go) begin
				if (widx == `UCR_IDX_CTRL_ONE && w_strb_q[0])
					ctrl_one_q[6:0] <= w_data_q[6:0]; // received ninth bit stays read-only
				if (widx == `UCR_IDX_CTRL_TWO && w_strb_q[0])
					ctrl_two_q <= w_data_q[7:0];
				if (widx == `UCR_IDX_PERIOD && w_strb_q[0])
					period_q[7:0] <= w_data_q[7:0];
				if (widx == `UCR_IDX_PERIOD && w_strb_q[1])
					period_q[15:8] <= w_data_q[15:8];
				if (widx == `UCR_IDX_DATA && w_strb_q[0]) begin
					tx_hold_q <= w_data_q[7:0];
					txbuf_empty_q <= 1'b0;
					if (flags_rd_q)
						tx_done_q <= 1'b0;
					flags_rd_q <= 1'b0;
				end
			end
			if (tx_take)
				txbuf_empty_q <= 1'b1; // R23
			if (tx_done_evt && txbuf_empty_q)
				tx_done_q <= 1'b1;
			// end of a received word, sampled on the stop bit
			if (rstate_q == R_BITS && rtick && rbits_q == (rnine_q ? 4'd9 : 4'd8)) begin
				if (!ctrl_two_q[`UCR_C2_MUTE] || (ctrl_one_q[`UCR_C1_ROUSE] && rx_msb)) begin
					if (ctrl_two_q[`UCR_C2_MUTE])
						ctrl_two_q[`UCR_C2_MUTE] <= 1'b0; // R18 R5
					if (rxbuf_full_q)
						overrun_q <= 1'b1; // buffer kept, new word lost
					else begin
						rx_data_q <= rword[7:0];
						if (rnine_q)
							ctrl_one_q[`UCR_C1_RX9] <= rword[8]; // R1
						rxbuf_full_q <= 1'b1;
						idle_armed_q <= 1'b1;
						if (!rx_pin)
							frame_err_q <= 1'b1;
						if (rx_par_bad)
							parity_fault_q <= 1'b1; // R6
					end
				end
			end
			// idle line: a full frame of ones, reported once per received word
			if (rstate_q == R_IDLE && rtick && ibits_q == frame_len - 4'h1 && idle_armed_q && rx_pin &&
				ctrl_two_q[`UCR_C2_RX_ON]) begin
				idle_armed_q <= 1'b0; // R19
				if (ctrl_two_q[`UCR_C2_MUTE] && !ctrl_one_q[`UCR_C1_ROUSE])
					ctrl_two_q[`UCR_C2_MUTE] <= 1'b0; // R18 R5
				else if (!ctrl_two_q[`UCR_C2_MUTE])
					idle_flag_q <= 1'b1;
			end
			if (ctrl_two_q[`UCR_C2_TX_ON])
				tx_ever_q <= 1'b1;
			// pin held while enabled; released in sleep once the shifter is idle
			tx_pin_oe_q <= (tx_ever_q | ctrl_two_q[`UCR_C2_TX_ON]) &
				(ctrl_two_q[`UCR_C2_TX_ON] | ctrl_two_q[`UCR_C2_RX_ON]) &
				~(ctrl_one_q[`UCR_C1_SLEEP] & ~tx_busy); // R16 R2
			// level request, follows the flags with one cycle of latency
			serial_irq_q <= (ctrl_one_q[`UCR_C1_PAR_IRQ] & parity_fault_q) | // R9
				(ctrl_two_q[`UCR_C2_TXBUF_IRQ] & txbuf_empty_q) | // R10
				(ctrl_two_q[`UCR_C2_TXDONE_IRQ] & tx_done_q) | // R11
				(ctrl_two_q[`UCR_C2_RXDATA_IRQ] & (overrun_q | rxbuf_full_q)) | // R12
				(ctrl_two_q[`UCR_C2_IDLE_IRQ] & idle_flag_q); // R13
		end
	end
endmodule

// ---- tb/ucr_serial_top_sva.sv ----
// Purpose: bus handshake and pin checks of the serial control block
// Assumes: bound to ucr_serial_top, clock enable mostly high
// Notes: bit timing on the serial line is judged by the bench
`timescale 1ns/10ps
module ucr_serial_top_sva (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire tx_pin,
	input wire tx_pin_oe_q
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// both write channels taken on one edge, answer one edge later
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
	endsequence
	property p_b_answer; s_wr_taken ##1 ce |=> s_axi_bvalid; endproperty
	a_b_answer: assert property (p_b_answer) else $error("write response late");
	property p_unmapped; s_wr_taken and (s_axi_awaddr > 8'h10) ##1 ce |=> s_axi_bresp == 2'h2; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped write not refused");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_release; s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid && s_axi_awready; endproperty
	a_b_release: assert property (p_b_release) else $error("write response not released");
	property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_block: assert property (p_aw_block) else $error("second write accepted early");
	property p_r_answer; s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("read data late");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("second read accepted early");
	// a low line must come from the block, never from a released pin
	property p_line_driven; !tx_pin |-> tx_pin_oe_q; endproperty
	a_line_driven: assert property (p_line_driven) else $error("line low while released");
	c_write: cover property (s_wr_taken);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_tx: cover property ($fell(tx_pin));
endmodule
bind ucr_serial_top ucr_serial_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .ce(ce),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .tx_pin(tx_pin), .tx_pin_oe_q(tx_pin_oe_q));

// ---- tb/ucr_remote_node.sv ----
// Purpose: remote serial node that sends words and decodes the block's frames
// Assumes: bit time is period clock cycles, line idles high
// Notes: decoder samples at bit centres; low runs are measured for break words
`timescale 1ns/10ps
module ucr_remote_node (
	input wire aclk,
	input wire [15:0] period,
	input wire nine,
	input wire tx_line,
	output reg rx_line
);
	reg [8:0] got;
	integer frames;
	integer low_run;
	integer last_low;
	integer i;
	initial begin
		rx_line = 1'b1;
		got = 9'h000;
		frames = 0;
		low_run = 0;
		last_low = 0;
	end
	// length of each low stretch, kept when the line rises
	always @(posedge aclk) begin
		if (tx_line === 1'b0) begin
			low_run <= low_run + 1;
		end else begin
			if (low_run != 0) last_low <= low_run;
			low_run <= 0;
		end
	end
	// frame decoder, lsb first, stop position waited out but not sampled
	initial forever begin
		@(posedge aclk);
		if (tx_line === 1'b0) begin
			repeat (period / 2) @(posedge aclk);
			for (i = 0; i < (nine ? 9 : 8); i = i + 1) begin
				repeat (period) @(posedge aclk);
				got[i] = tx_line;
			end
			if (!nine) got[8] = 1'b0;
			repeat (period) @(posedge aclk);
			frames = frames + 1;
		end
	end
	// one word: start, nb data bits lsb first, stop
	task send(input [8:0] w, input integer nb);
		integer k;
		begin
			@(posedge aclk);
			rx_line <= 1'b0;
			repeat (period) @(posedge aclk);
			for (k = 0; k < nb; k = k + 1) begin
				rx_line <= w[k];
				repeat (period) @(posedge aclk);
			end
			rx_line <= 1'b1;
			repeat (period + 2) @(posedge aclk);
		end
	endtask
endmodule

// ---- tb/tb_uart_control_registers.sv ----
// Purpose: self-checking bench of the serial control block
// Assumes: byte addresses of the hand-over map, clock enable held high
// Notes: short bit period keeps frames to tens of cycles
`timescale 1ns/10ps
module tb_uart_control_registers;
	localparam P = 4;
	reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, nine_q;
	reg [7:0] awaddr, araddr;
	reg [31:0] wdata, rd;
	reg [1:0] resp;
	wire awready, wready, bvalid, arready, rvalid, rx_pin, tx_pin, oe, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer mismatches, n_compared, cnt;
	ucr_serial_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .tx_pin_oe_q(oe), .serial_irq_q(irq));
	ucr_remote_node remote (.aclk(aclk), .period(16'h0004), .nine(nine_q), .tx_line(tx_pin), .rx_line(rx_pin));
	// 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task tally_and_finish;
		begin
			$display("compared %0d mismatches %0d", n_compared, mismatches);
			if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				$display("mismatch %s expected %h seen %h", nm, e, g);
				mismatches = mismatches + 1;
			end
		end
	endtask
	// write: both channels offered together, each dropped when taken
	task bw(input [7:0] a, input [31:0] d);
		begin
			@(posedge aclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			cnt = 0;
			do begin
				@(posedge aclk);
				cnt = cnt + 1;
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (!bvalid && cnt < 200);
			resp = bresp;
			bready <= 1'b0;
			if (cnt >= 200) chk("write wait", 1, 0);
		end
	endtask
	task br(input [7:0] a);
		begin
			@(posedge aclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			cnt = 0;
			do begin
				@(posedge aclk);
				cnt = cnt + 1;
				if (arready) arvalid <= 1'b0;
			end while (!rvalid && cnt < 200);
			rd = rdata;
			resp = rresp;
			rready <= 1'b0;
			if (cnt >= 200) chk("read wait", 1, 0);
		end
	endtask
	task wait_frame;
		begin
			cnt = remote.frames;
			repeat (2000) if (remote.frames == cnt) @(posedge aclk);
			if (remote.frames == cnt) chk("frame wait", 1, 0);
			repeat (P + 2) @(posedge aclk);
		end
	endtask
	task t_reset;
		begin
			br(8'h00);
			chk("ctrl_one", 32'h0, rd & 32'h7f);
			br(8'h04);
			chk("ctrl_two", 32'h0, rd);
			br(8'h08);
			chk("flags", 32'hc0, rd);
			bw(8'h20, 32'h0);
			chk("unmapped wr", 2'h2, resp);
			br(8'h20);
			chk("unmapped rd", 2'h2, resp);
		end
	endtask
	task t_irq;
		begin
			bw(8'h04, 32'h80);
			repeat (3) @(posedge aclk);
			chk("irq txbuf", 1, irq);
			bw(8'h04, 32'h40);
			repeat (3) @(posedge aclk);
			chk("irq txdone", 1, irq);
			bw(8'h04, 32'h00);
			repeat (3) @(posedge aclk);
			chk("irq off", 0, irq);
		end
	endtask
	// parity replaces bit 7, even then odd; then a nine-bit word
	task t_tx;
		begin
			bw(8'h10, P);
			bw(8'h00, 32'h04);
			bw(8'h0c, 32'hb5);
			bw(8'h04, 32'h08);
			cnt = 0;
			while (tx_pin !== 1'b0 && cnt < 100) begin
				@(posedge aclk);
				cnt = cnt + 1;
			end
			// edge detect and frame launch each add one cycle to the bit of idle
			chk("idle bit", P + 2, cnt);
			chk("pin driven", 1, oe);
			wait_frame;
			chk("even word", 9'h035, remote.got);
			bw(8'h00, 32'h06);
			bw(8'h0c, 32'h35);
			wait_frame;
			chk("odd word", 9'h0b5, remote.got);
			nine_q <= 1'b1;
			bw(8'h00, 32'h50);
			bw(8'h0c, 32'h12);
			wait_frame;
			chk("nine tx", 9'h112, remote.got);
		end
	endtask
	task t_rx;
		begin
			bw(8'h00, 32'h10);
			bw(8'h04, 32'h2c);
			remote.send(9'h1a5, 9);
			chk("irq rx", 1, irq);
			br(8'h08);
			chk("rx full", 1, rd[5]);
			br(8'h0c);
			chk("rx data", 8'ha5, rd[7:0]);
			br(8'h00);
			chk("rx ninth", 1, rd[7]);
			repeat (3) @(posedge aclk);
			chk("irq rx off", 0, irq);
		end
	endtask
	// break set then cleared: the break sent while set plus the pending one, back to back, 8-bit word
	task t_brk;
		begin
			nine_q <= 1'b0;
			bw(8'h00, 32'h00);
			bw(8'h04, 32'h09);
			bw(8'h04, 32'h08);
			wait_frame;
			chk("break word", 9'h000, remote.got);
			cnt = 0;
			while (tx_pin === 1'b0 && cnt < 200) begin
				@(posedge aclk);
				cnt = cnt + 1;
			end
			@(posedge aclk);
			chk("break length", 20 * P, remote.last_low);
		end
	endtask
	// address-mark wake: msb clear ignored, msb set wakes and is stored
	task t_mute;
		begin
			bw(8'h00, 32'h08);
			bw(8'h04, 32'h06);
			remote.send(9'h001, 8);
			remote.send(9'h081, 8);
			br(8'h04);
			chk("mute cleared", 0, rd[1]);
			br(8'h0c);
			chk("woken data", 8'h81, rd[7:0]);
		end
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches = mismatches + 1;
		tally_and_finish;
	end
	initial begin
		mismatches = 0;
		n_compared = 0;
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		nine_q = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_irq;
		t_tx;
		t_rx;
		t_brk;
		t_mute;
		tally_and_finish;
	end
endmodule
